// [acss_top.sv]
// serial control slave: three stored control registers, strap-selected hardware mode, wake timer
// assumes scl/sda pins are asynchronous and sampled at 20 MHz; bus at most 400 kHz
//
// Behaviour
// - slave only: clock never driven, data open-drain, up to 400 kHz
// - respond to address 1101111 in upper seven bits, R/W in bit 0
// - every byte eight bits followed by an acknowledge slot
// - on address match pull data low during the ninth clock
// - data stable while clock high, taken on rising edge, MSB first
// - write: address, index, data stored into indexed register, each acknowledged
// - read: address, index, then indexed byte shifted out MSB first
// - four registers at indices 0 to 3, unused bits kept zero; index 3 is not stored here, writes to it are ignored and it reads zero
// - reg1 bits 6:5 choose limiter release coefficient
// - reg1 bits 4:3 choose limiter attack coefficient
// - reg1 bits 2:0 limit threshold, 000 and 111 disable it
// - strap low: data/clock pins pick input and gain, fixed boost per input
// - reg2 bits 1:0 gain code, boost picks upper gain set
// - limiter only in register mode with boost on
`timescale 1ns/1ns
`include "acss_map.svh"
module acss_top #(
  parameter int WAKE_SLOW_CYC = `ACSS_WAKE_SLOW_CYC,
  parameter int WAKE_FAST_CYC = `ACSS_WAKE_FAST_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic control_source_strap_in,
  output logic power_down_n_out,
  output logic second_input_out,
  output logic boost_en_out,
  output logic [1:0] amp_gain_out,
  output logic [1:0] release_coef_out,
  output logic [1:0] attack_coef_out,
  output logic [2:0] limit_level_out,
  output logic output_limiter_out,
  output logic awake_out
);
  import acss_pkg::*;
  initial begin
    if (WAKE_FAST_CYC < 1 || WAKE_SLOW_CYC < WAKE_FAST_CYC)
      $error("acss_top: wake counts invalid");
  end
  logic scl_s, sda_s, strap_s, scl_d, sda_d;
  acss_sync #(.WIDTH(3)) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in({scl_in, sda_in, control_source_strap_in}),
    .sync_out({scl_s, sda_s, strap_s})
  );
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  acss_state_t state, ret_state;
  acss_byte_t shreg, index, rdbuf;
  logic [3:0] bitcnt;
  logic rd_req;
  logic sw_mode;
  acss_byte_t reg_pwr, reg_lim, reg_gain;
  acss_byte_t rd_value;
  logic wr_stb;
  always_comb begin
    case (index)
      `ACSS_REG_PWR: rd_value = reg_pwr;
      `ACSS_REG_LIM: rd_value = reg_lim;
      `ACSS_REG_GAIN: rd_value = reg_gain;
      default: rd_value = `ACSS_RST_VAL;
    endcase
  end
  // bus protocol engine; the receiver is never driving scl
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ACSS_IDLE;
      ret_state <= ACSS_IDLE;
      shreg <= 8'h00;
      index <= 8'h00;
      rdbuf <= 8'h00;
      bitcnt <= 4'h0;
      rd_req <= 1'b0;
      wr_stb <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (!sw_mode || stop_det) begin
        state <= ACSS_IDLE;
        sda_oe_out <= 1'b0;
      end else if (start_det) begin
        state <= ACSS_ADDR;
        bitcnt <= 4'h0;
        sda_oe_out <= 1'b0;
      end else begin
        case (state)
          ACSS_ADDR, ACSS_INDEX, ACSS_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == ACSS_ADDR) begin
                if (shreg[7:1] == `ACSS_SLAVE_ADDR) begin
                  rd_req <= shreg[0];
                  sda_oe_out <= 1'b1;
                  state <= ACSS_ACK;
                  ret_state <= ACSS_INDEX;
                end else begin
                  state <= ACSS_IDLE;
                end
              end else if (state == ACSS_INDEX) begin
                index <= shreg;
                sda_oe_out <= 1'b1;
                state <= ACSS_ACK;
                ret_state <= rd_req ? ACSS_RDATA : ACSS_WDATA;
              end else begin
                wr_stb <= 1'b1;
                sda_oe_out <= 1'b1;
                state <= ACSS_ACK;
                ret_state <= ACSS_DONE;
              end
            end
          end
          ACSS_ACK: begin
            if (scl_fall) begin
              if (ret_state == ACSS_RDATA) begin
                rdbuf <= {rd_value[6:0], 1'b0};
                sda_oe_out <= !rd_value[7];
                bitcnt <= 4'h1;
              end else begin
                sda_oe_out <= 1'b0;
                bitcnt <= 4'h0;
              end
              state <= ret_state;
            end
          end
          ACSS_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe_out <= 1'b0;
                state <= ACSS_DONE;
              end else begin
                sda_oe_out <= !rdbuf[7];
                rdbuf <= {rdbuf[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ACSS_DONE: sda_oe_out <= 1'b0;
          default: sda_oe_out <= 1'b0;
        endcase
      end
    end
  end
  assign sda_out = 1'b0;
  // register file; unused bits forced to zero
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_pwr <= `ACSS_RST_VAL;
      reg_lim <= `ACSS_RST_VAL;
      reg_gain <= `ACSS_RST_VAL;
    end else if (wr_stb) begin
      case (index)
        `ACSS_REG_PWR: reg_pwr <= shreg & `ACSS_PWR_MASK;
        `ACSS_REG_LIM: reg_lim <= shreg & `ACSS_LIM_MASK;
        `ACSS_REG_GAIN: reg_gain <= shreg & `ACSS_GAIN_MASK;
        default: reg_pwr <= reg_pwr;
      endcase
    end
  end
  // strap followed continuously via synchroniser
  assign sw_mode = strap_s;
  // control outputs
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      power_down_n_out <= 1'b0;
      second_input_out <= 1'b0;
      boost_en_out <= 1'b0;
      amp_gain_out <= 2'h0;
      release_coef_out <= 2'h0;
      attack_coef_out <= 2'h0;
      limit_level_out <= 3'h0;
      output_limiter_out <= 1'b0;
    end else if (sw_mode) begin
      power_down_n_out <= reg_pwr[`ACSS_BIT_ON];
      second_input_out <= reg_pwr[`ACSS_BIT_INSEL];
      boost_en_out <= reg_pwr[`ACSS_BIT_BOOST];
      amp_gain_out <= reg_gain[1:0];
      release_coef_out <= reg_lim[6:5];
      attack_coef_out <= reg_lim[4:3];
      limit_level_out <= reg_lim[2:0];
      output_limiter_out <= reg_pwr[`ACSS_BIT_BOOST] && reg_lim[2:0] != 3'h0
        && reg_lim[2:0] != 3'h7;
    end else begin
      // data pin picks input+boost; clock pin steps 0/6 dB or 24/30 dB
      power_down_n_out <= 1'b1;
      second_input_out <= sda_s;
      boost_en_out <= sda_s;
      amp_gain_out <= {sda_s & scl_s, sda_s | scl_s};
      release_coef_out <= 2'h0;
      attack_coef_out <= 2'h0;
      limit_level_out <= 3'h0;
      output_limiter_out <= 1'b0;
    end
  end
  // wake timer after enable
  logic [31:0] wake_cnt;
  logic prev_on;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_cnt <= 32'h0;
      prev_on <= 1'b0;
      awake_out <= 1'b0;
    end else begin
      prev_on <= power_down_n_out;
      if (!power_down_n_out) begin
        awake_out <= 1'b0;
        wake_cnt <= 32'h0;
      end else if (!prev_on) begin
        wake_cnt <= (sw_mode && reg_pwr[`ACSS_BIT_TURNON]) ? 32'(WAKE_FAST_CYC)
          : 32'(WAKE_SLOW_CYC);
      end else if (wake_cnt > 32'h1) begin
        wake_cnt <= wake_cnt - 32'h1;
      end else begin
        awake_out <= 1'b1;
      end
    end
  end
endmodule

// [acss_map.svh]
// register map, field positions and timing constants of the amp control serial slave
// assumes inclusion by acss_pkg and the design modules; definitions only
`ifndef ACSS_MAP_SVH
`define ACSS_MAP_SVH
`define ACSS_SLAVE_ADDR 7'h6F
`define ACSS_REG_PWR 8'h00
`define ACSS_REG_LIM 8'h01
`define ACSS_REG_GAIN 8'h02
`define ACSS_REG_TEST 8'h03
`define ACSS_PWR_MASK 8'h0F
`define ACSS_LIM_MASK 8'h7F
`define ACSS_GAIN_MASK 8'h03
`define ACSS_RST_VAL 8'h00
`define ACSS_BIT_ON 0
`define ACSS_BIT_BOOST 1
`define ACSS_BIT_INSEL 2
`define ACSS_BIT_TURNON 3
`define ACSS_MAX_SCL_KHZ 400
`define ACSS_CLK_KHZ 20000
`define ACSS_WAKE_SLOW_MS 15
`define ACSS_WAKE_FAST_MS 5
`define ACSS_WAKE_SLOW_CYC (`ACSS_WAKE_SLOW_MS * `ACSS_CLK_KHZ)
`define ACSS_WAKE_FAST_CYC (`ACSS_WAKE_FAST_MS * `ACSS_CLK_KHZ)
`endif

// [acss_pkg.sv]
// types of the amp control serial slave
// assumes acss_map.svh is on the include path
`include "acss_map.svh"
package acss_pkg;
  typedef enum logic [2:0] {
    ACSS_IDLE = 3'b000,
    ACSS_ADDR = 3'b001,
    ACSS_INDEX = 3'b010,
    ACSS_WDATA = 3'b011,
    ACSS_RDATA = 3'b100,
    ACSS_ACK = 3'b101,
    ACSS_DONE = 3'b110
  } acss_state_t;
  typedef logic [7:0] acss_byte_t;
endpackage

// [acss_sync.sv]
// two-flop synchroniser for a group of pin inputs
// assumes inputs asynchronous to ref_clk_in
`timescale 1ns/1ns
module acss_sync #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  initial begin
    if (WIDTH < 1) $error("acss_sync: WIDTH must be positive");
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // pins idle high on pull-ups: resetting low would fake edges and a mode flip
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [acss_chk.sv]
// assertions on the serial control slave ports
// assumes binding onto acss_top, one clock domain
`timescale 1ns/1ns
module acss_chk (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic control_source_strap_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic power_down_n_out,
  input wire logic second_input_out,
  input wire logic boost_en_out,
  input wire logic [1:0] amp_gain_out,
  input wire logic [2:0] limit_level_out,
  input wire logic output_limiter_out,
  input wire logic awake_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_hw; !control_source_strap_in [*8]; endsequence
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_lim; output_limiter_out |-> boost_en_out && limit_level_out != 3'h0
    && limit_level_out != 3'h7; endproperty
  a_lim: assert property (p_lim) else $error("limiter on");
  property p_hw_lim; s_hw |-> !output_limiter_out; endproperty
  a_hw_lim: assert property (p_hw_lim) else $error("hw limiter");
  property p_hw_map; s_hw |-> power_down_n_out && second_input_out == boost_en_out
    && (boost_en_out ? amp_gain_out[0] : !amp_gain_out[1]); endproperty
  a_hw_map: assert property (p_hw_map) else $error("hw map");
  property p_hw_quiet; s_hw |-> !sda_oe_out; endproperty
  a_hw_quiet: assert property (p_hw_quiet) else $error("hw drive");
  property p_oe_edge; $changed(sda_oe_out) |-> !scl_in; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data moved");
  property p_ack_hold; $rose(sda_oe_out) |=> sda_oe_out [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("pull short");
  property p_wake; $rose(power_down_n_out) |=> !awake_out [*8]; endproperty
  a_wake: assert property (p_wake) else $error("awake early");
  c_ack: cover property ($rose(sda_oe_out));
  c_lim: cover property ($rose(output_limiter_out));
  c_hw: cover property (s_hw);
endmodule
bind acss_top acss_chk u_chk (.ref_clk_in, .nrst_in, .scl_in, .control_source_strap_in,
  .sda_out, .sda_oe_out, .power_down_n_out, .second_input_out, .boost_en_out,
  .amp_gain_out, .limit_level_out, .output_limiter_out, .awake_out);

// [acss_master.sv]
// bus master model: makes the clock, frames three bytes per transfer (address, index, data)
// assumes a pull-up: data wire is low when either side pulls
`timescale 1ns/1ns
module acss_master (
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // 50 cycles a bit keeps the bus at 400 kHz
  task automatic bit_io(input logic v, output logic r);
    sda_out <= v;
    tk(12);
    scl_out <= 1'b1;
    tk(25);
    r = sda_in;
    scl_out <= 1'b0;
    tk(13);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic am, output logic [7:0] q,
      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q[i] = b;
    end
    bit_io(am, ack);
  endtask
  // read when a[0] is set: byte released, then acked by the master
  task automatic frame(input logic [7:0] a, i, d, output logic [7:0] q,
      output logic [2:0] k);
    sda_out <= 1'b0;
    tk(12);
    scl_out <= 1'b0;
    tk(13);
    xbyte(a, 1'b1, q, k[2]);
    xbyte(i, 1'b1, q, k[1]);
    xbyte(a[0] ? 8'hFF : d, !a[0], q, k[0]);
    sda_out <= 1'b0;
    tk(12);
    scl_out <= 1'b1;
    tk(12);
    sda_out <= 1'b1;
    tk(25);
  endtask
endmodule

// [amp_control_serial_slave_test.sv]
// self-checking bench for the serial control slave
// assumes acss_master as bus master, pull-up on data
`timescale 1ns/1ns
module amp_control_serial_slave_test;
  import acss_pkg::*;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic strap = 1'b1;
  logic scl, sda_m, oe, so, po, si, be, lo, aw;
  logic [1:0] gn, rc, ac;
  logic [2:0] ll;
  wire sda = sda_m & ~oe;
  int failures = 0;
  int checks = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  acss_top #(.WAKE_SLOW_CYC(20), .WAKE_FAST_CYC(10)) uut (.ref_clk_in, .nrst_in,
    .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_out(oe), .control_source_strap_in(strap),
    .power_down_n_out(po), .second_input_out(si), .boost_en_out(be), .amp_gain_out(gn),
    .release_coef_out(rc), .attack_coef_out(ac), .limit_level_out(ll),
    .output_limiter_out(lo), .awake_out(aw));
  acss_master m (.ref_clk_in, .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
  task automatic chk(input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rw(input logic [7:0] a, i, d, exp, ka);
    logic [7:0] q;
    logic [2:0] k;
    m.frame(a, i, d, q, k);
    chk(k, ka);
    chk(so, 8'h00);
    if (a[0])
      chk(q, exp);
  endtask
  task automatic t_regs;
    rw(8'hDF, 8'h00, 8'h00, 8'h00, 8'h00);
    chk({po, be, si, aw, lo}, 8'h00);
    rw(8'hDE, 8'h00, 8'h0F, 8'h00, 8'h00);
    chk({po, be, si, aw}, 8'h0F);
    rw(8'hDF, 8'h00, 8'h00, 8'h0F, 8'h00);
    rw(8'hDE, 8'h03, 8'hA5, 8'h00, 8'h00);
    rw(8'hDF, 8'h03, 8'h00, 8'h00, 8'h00);
    $display("registers done");
  endtask
  task automatic t_lim;
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {1'b0, c[1:0], c[1:0], 3'(c * 7)};
      rw(8'hDE, 8'h01, v, 8'h00, 8'h00);
      chk({rc, ac, ll}, v);
      chk(lo, v[2:0] != 3'h0 && v[2:0] != 3'h7);
      rw(8'hDF, 8'h01, 8'h00, v, 8'h00);
    end
    $display("limiter done");
  endtask
  task automatic t_gain;
    rw(8'hDE, 8'h00, 8'h0D, 8'h00, 8'h00);
    chk({lo, be}, 8'h00);
    for (int c = 0; c < 4; c++) begin
      rw(8'hDE, 8'h02, 8'(c), 8'h00, 8'h00);
      chk(gn, 8'(c));
    end
    rw(8'hDC, 8'h02, 8'h00, 8'h00, 8'h07);
    rw(8'hDF, 8'h02, 8'h00, 8'h03, 8'h00);
    $display("gain done");
  endtask
  task automatic t_hw;
    logic [7:0] e;
    rw(8'hDE, 8'h00, 8'h00, 8'h00, 8'h00);
    strap <= 1'b0;
    // slow wake: power on 3 cycles after strap, awake 21 cycles later
    m.tk(18);
    chk(aw, 8'h00);
    for (int c = 0; c < 4; c++) begin
      m.sda_out <= c[1];
      m.scl_out <= c[0];
      m.tk(10);
      e = {2'b00, 1'b1, c[1], c[1], c[1] & c[0], c[1] | c[0], 1'b0};
      chk({po, si, be, gn, lo}, e);
    end
    chk(aw, 8'h01);
    strap <= 1'b1;
    m.tk(10);
    $display("hardware mode done");
  endtask
  initial begin
    m.tk(12);
    nrst_in <= 1'b1;
    m.tk(4);
    t_regs();
    t_lim();
    t_gain();
    t_hw();
    wrap_up();
  end
  initial begin
    m.tk(60000);
    failures++;
    wrap_up();
  end
endmodule
